// ===== inc/imh_pkg.sv
// constants for the high interrupt mask byte of the interrupt unit
// assumes a byte register port from the core and one core clock
// Operation
// - each mask bit enables its source when one and masks it when zero.
// - the global on and off instructions enable or disable all maskable servicing at once.
// - the mask register is read and written as one byte by the core.
// - push-all saves the mask byte to the stack and pop-all restores it.
// - the mask register sits at address 13h and resets to zero.
// - a taken source vectors to its fixed location, nonmaskable highest, stepping down by two.
package imh_pkg;
	localparam logic [15:0] IMH_ADDR_MASK = 16'h0013;
	localparam logic [15:0] IMH_ADDR_STATUS = 16'h0014;
	localparam logic [15:0] IMH_ADDR_CLEAR = 16'h0015;
	localparam logic [15:0] IMH_ADDR_ENABLE = 16'h0016;
	localparam logic [7:0] IMH_MASK_RESET = 8'h00;
	localparam logic [15:0] IMH_VECTOR_TOP = 16'h203e;
	localparam logic [15:0] IMH_VECTOR_STEP = 16'h0002;
	localparam int IMH_NMI_BIT = 7;
endpackage

// ===== rtl/imh_mask_high.sv
// high interrupt mask byte with global enable, stack save/restore and vector select
// assumes the core pulses one instruction strobe at a time and ignores reads of write-only regs
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/100ps
module imh_mask_high
	import imh_pkg::*;
#(
	parameter int NUM_SRC = 8
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// register port
	input wire logic [15:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [7:0] reg_rdata,
	// instruction strobes from the core
	input wire logic global_irq_on_instruction,
	input wire logic global_irq_off_instruction,
	input wire logic push_all_instruction,
	input wire logic pop_all_instruction,
	input wire logic [7:0] pop_data,
	output logic [7:0] push_data,
	// sources and request to the core
	input wire logic [NUM_SRC-1:0] irq_pending,
	input wire logic vector_take,
	output logic irq_request,
	output logic [15:0] vector_addr,
	output logic irq_line
);
	logic [7:0] interrupt_mask_high;
	logic global_enable;
	logic [7:0] status;
	logic [7:0] enable;
	logic [7:0] gated;
	logic [2:0] winner;
	logic [2:0] winner_q;

	// pop-all loads after a same-cycle write would be odd; pop wins as the later stack effect
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			interrupt_mask_high <= IMH_MASK_RESET;
		end else if (pop_all_instruction) begin
			interrupt_mask_high <= pop_data;
		end else if (reg_write && reg_addr == IMH_ADDR_MASK) begin
			interrupt_mask_high <= reg_wdata;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			global_enable <= 1'b0;
		end else if (global_irq_off_instruction) begin
			global_enable <= 1'b0;
		end else if (global_irq_on_instruction) begin
			global_enable <= 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			push_data <= 8'h00;
		end else if (push_all_instruction) begin
			push_data <= interrupt_mask_high;
		end
	end

	// nonmaskable bit ignores the global enable
	always_comb begin
		gated = irq_pending & interrupt_mask_high;
		if (!global_enable) begin
			gated = gated & (8'h01 << IMH_NMI_BIT);
		end
	end

	always_comb begin
		winner = 3'd0;
		for (int i = 0; i < NUM_SRC; i++) begin
			if (gated[i]) begin
				winner = 3'(i);
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			irq_request <= 1'b0;
			vector_addr <= 16'h0000;
			winner_q <= 3'd0;
		end else begin
			// the core acts on this registered pair, so the named source travels with it
			irq_request <= |gated;
			vector_addr <= IMH_VECTOR_TOP - IMH_VECTOR_STEP * 16'(7 - winner);
			winner_q <= winner;
		end
	end

	// sticky event flags: a new take beats a clear in the same cycle
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			status <= 8'h00;
		end else begin
			status <= (status & ~((reg_write && reg_addr == IMH_ADDR_CLEAR) ? reg_wdata : 8'h00))
				| ((vector_take && irq_request) ? (8'h01 << winner_q) : 8'h00);
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			enable <= 8'h00;
		end else if (reg_write && reg_addr == IMH_ADDR_ENABLE) begin
			enable <= reg_wdata;
		end
	end

	// level output: stays high until software clears the flag or drops its enable
	assign irq_line = |(status & enable);

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			reg_rdata <= 8'h00;
		end else if (reg_read) begin
			unique case (reg_addr)
				IMH_ADDR_MASK: reg_rdata <= interrupt_mask_high;
				IMH_ADDR_STATUS: reg_rdata <= status;
				IMH_ADDR_ENABLE: reg_rdata <= enable;
				default: reg_rdata <= 8'h00;
			endcase
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	// single-cycle conditions are spelt out once and reused by the properties below
	sequence s_mask_write;
		reg_write && reg_addr == IMH_ADDR_MASK && !pop_all_instruction;
	endsequence

	sequence s_mask_read;
		reg_read && reg_addr == IMH_ADDR_MASK && !reg_write && !pop_all_instruction;
	endsequence

	sequence s_take;
		vector_take && irq_request;
	endsequence

	a_reset_mask: assert property (@(posedge clk_sys)
		$rose(rst_b) |-> interrupt_mask_high == IMH_MASK_RESET)
		else $error("mask not zero after reset");
	a_reset_outputs: assert property (@(posedge clk_sys)
		$rose(rst_b) |-> !irq_request && !global_enable && push_data == 8'h00)
		else $error("outputs not idle after reset");
	a_mask_gates_req: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(irq_pending & interrupt_mask_high) == 8'h00 |=> !irq_request)
		else $error("request from masked source");
	a_enabled_req: assert property (@(posedge clk_sys) disable iff (!rst_b)
		global_enable && (irq_pending & interrupt_mask_high) != 8'h00 |=> irq_request)
		else $error("unmasked source not requested");
	a_global_off: assert property (@(posedge clk_sys) disable iff (!rst_b)
		global_irq_off_instruction |=> !global_enable)
		else $error("global disable ignored");
	a_global_on: assert property (@(posedge clk_sys) disable iff (!rst_b)
		global_irq_on_instruction && !global_irq_off_instruction |=> global_enable)
		else $error("global enable ignored");
	a_global_hold: assert property (@(posedge clk_sys) disable iff (!rst_b)
		!global_irq_on_instruction && !global_irq_off_instruction |=> $stable(global_enable))
		else $error("global enable moved on its own");
	// bit 7 is the nonmaskable source, so only it survives a global off
	a_global_gate: assert property (@(posedge clk_sys) disable iff (!rst_b)
		!global_enable && !(irq_pending[7] && interrupt_mask_high[7]) |=> !irq_request)
		else $error("maskable request while globally off");

	a_write_read: assert property (@(posedge clk_sys) disable iff (!rst_b)
		s_mask_write ##1 s_mask_read |=> reg_rdata == $past(reg_wdata, 2))
		else $error("mask readback wrong");
	a_mask_readback: assert property (@(posedge clk_sys) disable iff (!rst_b)
		reg_read && reg_addr == IMH_ADDR_MASK |=> reg_rdata == $past(interrupt_mask_high))
		else $error("mask read data wrong");
	a_mask_hold: assert property (@(posedge clk_sys) disable iff (!rst_b)
		!pop_all_instruction && !(reg_write && reg_addr == IMH_ADDR_MASK)
		|=> $stable(interrupt_mask_high))
		else $error("mask changed without write or pop");
	// unmapped and write-only addresses read as zero so software never sees stale bytes
	a_unmapped_read: assert property (@(posedge clk_sys) disable iff (!rst_b)
		reg_read && reg_addr != IMH_ADDR_MASK && reg_addr != IMH_ADDR_STATUS
		&& reg_addr != IMH_ADDR_ENABLE |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_rdata_idle: assert property (@(posedge clk_sys) disable iff (!rst_b)
		!reg_read |=> reg_rdata == 8'h00)
		else $error("read data outside its cycle");

	a_push_saves: assert property (@(posedge clk_sys) disable iff (!rst_b)
		push_all_instruction |=> push_data == $past(interrupt_mask_high))
		else $error("push lost mask");
	a_push_hold: assert property (@(posedge clk_sys) disable iff (!rst_b)
		!push_all_instruction |=> $stable(push_data))
		else $error("pushed byte changed");
	a_pop_restores: assert property (@(posedge clk_sys) disable iff (!rst_b)
		pop_all_instruction |=> interrupt_mask_high == $past(pop_data))
		else $error("pop did not restore");

	a_nmi_vector: assert property (@(posedge clk_sys) disable iff (!rst_b)
		irq_pending[7] && interrupt_mask_high[7] |=> vector_addr == IMH_VECTOR_TOP)
		else $error("nonmaskable vector wrong");
	a_pin_vector: assert property (@(posedge clk_sys) disable iff (!rst_b)
		global_enable && irq_pending[6] && interrupt_mask_high[6]
		&& !(irq_pending[7] && interrupt_mask_high[7])
		|=> vector_addr == IMH_VECTOR_TOP - IMH_VECTOR_STEP)
		else $error("external pin vector wrong");
	a_idle_vector: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(irq_pending & interrupt_mask_high) == 8'h00 |=> vector_addr == 16'h2030)
		else $error("idle vector wrong");

	a_status_set: assert property (@(posedge clk_sys) disable iff (!rst_b)
		s_take |=> status[$past(winner_q)])
		else $error("taken source not flagged");
	a_status_clear: assert property (@(posedge clk_sys) disable iff (!rst_b)
		reg_write && reg_addr == IMH_ADDR_CLEAR && !vector_take
		|=> (status & $past(reg_wdata)) == 8'h00)
		else $error("status clear ignored");
	a_status_hold: assert property (@(posedge clk_sys) disable iff (!rst_b)
		!vector_take && !(reg_write && reg_addr == IMH_ADDR_CLEAR) |=> $stable(status))
		else $error("status moved without take or clear");
endmodule // imh_mask_high

// ===== sim/interrupt_mask_high_byte_tb_top.sv
// self-checking bench for the high interrupt mask byte
// assumes imh_pkg is compiled first and imh_mask_high answers one cycle after each strobe
`timescale 1ns/100ps
module interrupt_mask_high_byte_tb_top
	import imh_pkg::*;
;
	logic clk_sys = 0, rst_b = 0, reg_write = 0, reg_read = 0, rd_d = 0;
	logic [15:0] reg_addr = 0, vector_addr;
	logic [7:0] reg_wdata = 0, pop_data = 0, irq_pending = 0, reg_rdata, push_data, m;
	logic [4:0] ins = 0;
	logic irq_request, irq_line;
	logic [31:0] seed = 32'd14;
	logic [7:0] q[$];
	int n_errors = 0, checks = 0, cyc = 0;
	imh_mask_high u_imh_mask_high (.clk_sys, .rst_b, .reg_addr, .reg_wdata, .reg_write, .reg_read,
		.reg_rdata, .global_irq_on_instruction(ins[4]), .global_irq_off_instruction(ins[3]),
		.push_all_instruction(ins[2]), .pop_all_instruction(ins[1]), .pop_data, .push_data,
		.irq_pending, .vector_take(ins[0]), .irq_request, .vector_addr, .irq_line);
	always #12.5 clk_sys = ~clk_sys;
	function logic [7:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[7:0];
	endfunction
	task chk(input logic [15:0] s, input logic [15:0] e);
		checks++;
		if (s !== e) begin
			n_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task tally_and_finish();
		$display("errors %0d checks %0d", n_errors, checks);
		if (n_errors == 0 && checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		{reg_write, reg_addr, reg_wdata} <= {1'b1, a, d};
		@(posedge clk_sys);
		reg_write <= 0;
	endtask
	task rd(input logic [15:0] a, input logic [7:0] e);
		@(posedge clk_sys);
		{reg_read, reg_addr} <= {1'b1, a};
		q.push_back(e);
		@(posedge clk_sys);
		reg_read <= 0;
	endtask
	// write then read the same address with no idle cycle between the strobes
	task wr_rd(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		{reg_write, reg_addr, reg_wdata} <= {1'b1, a, d};
		@(posedge clk_sys);
		{reg_write, reg_read} <= 2'b01;
		q.push_back(d);
		@(posedge clk_sys);
		reg_read <= 0;
	endtask
	// one instruction strobe: 4 on, 3 off, 2 push, 1 pop, 0 take
	task strobe(input int k);
		@(posedge clk_sys);
		ins <= 5'h01 << k;
		@(posedge clk_sys);
		ins <= 0;
	endtask
	task settle();
		repeat (3) @(posedge clk_sys);
		#1;
	endtask
	// read data stand only in the cycle after the strobe, so compare at the edge closing it
	always @(posedge clk_sys) begin
		rd_d <= reg_read;
		cyc <= cyc + 1;
		if (rd_d) chk(reg_rdata, q.pop_front());
		if (cyc == 3000) begin
			n_errors++;
			tally_and_finish();
		end
	end
	initial begin
		repeat (3) @(posedge clk_sys);
		rst_b <= 1;
		rd(IMH_ADDR_MASK, IMH_MASK_RESET);
		m = rnd();
		wr(IMH_ADDR_MASK, m);
		rd(IMH_ADDR_MASK, m);
		rd(16'h0020, 8'h00);
		m = rnd();
		wr_rd(IMH_ADDR_MASK, m);
		strobe(2);
		#1 chk(push_data, m);
		m = rnd();
		pop_data <= m;
		strobe(1);
		rd(IMH_ADDR_MASK, m);
		irq_pending <= rnd() | 8'h80;
		wr(IMH_ADDR_MASK, 8'h80);
		settle();
		chk(irq_request, 1'b1);
		wr(IMH_ADDR_MASK, 8'h7f);
		irq_pending <= 8'h7f;
		settle();
		chk(irq_request, 1'b0);
		strobe(4);
		for (int i = 0; i < 8; i++) begin
			irq_pending <= 8'hff;
			wr(IMH_ADDR_MASK, 8'h01 << i);
			settle();
			chk(irq_request, 1'b1);
			chk(vector_addr, 16'(IMH_VECTOR_TOP - IMH_VECTOR_STEP * (7 - i)));
			irq_pending <= ~(8'h01 << i);
			settle();
			chk(irq_request, 1'b0);
		end
		irq_pending <= 8'h40;
		wr(IMH_ADDR_MASK, 8'h40);
		wr(IMH_ADDR_ENABLE, 8'hff);
		settle();
		strobe(0);
		settle();
		chk(irq_line, 1'b1);
		rd(IMH_ADDR_STATUS, 8'h40);
		wr(IMH_ADDR_ENABLE, 8'hbf);
		settle();
		chk(irq_line, 1'b0);
		wr(IMH_ADDR_ENABLE, 8'hff);
		wr(IMH_ADDR_CLEAR, 8'h40);
		irq_pending <= 0;
		settle();
		chk(irq_line, 1'b0);
		rd(IMH_ADDR_ENABLE, 8'hff);
		rd(IMH_ADDR_CLEAR, 8'h00);
		irq_pending <= 8'h40;
		strobe(3);
		settle();
		chk(irq_request, 1'b0);
		tally_and_finish();
	end
endmodule // interrupt_mask_high_byte_tb_top
